// ### hdl/swg_pkg.sv
// Purpose: shared constants and types for the serial eeprom write guard
// Assumes: spi mode 0 or 3, msb first, 16-bit address, 8-bit data
// Notes: opcode values are parameters of plain default value
package swg_pkg;
   localparam int unsigned CLK_PERIOD_NS = 4;
   // self-timed write length
   localparam int unsigned WRITE_TIME_NS = 5000;
   localparam int unsigned WRITE_CYCLES = (WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [7:0] OP_SET_LATCH = 8'h06;
   localparam logic [7:0] OP_CLEAR_LATCH = 8'h04;
   localparam logic [7:0] OP_READ_STATUS = 8'h05;
   localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
   localparam logic [7:0] OP_READ = 8'h03;
   localparam logic [7:0] OP_WRITE = 8'h02;
   localparam int unsigned OPCODE_BITS = 8;
   localparam int unsigned STATUS_WR_BITS = 16;
   localparam int unsigned ARRAY_WR_MIN_BITS = 32;
   localparam int unsigned BYTE_BITS = 8;
   localparam int unsigned STATUS_READY_POS = 0;
   localparam int unsigned STATUS_LATCH_POS = 1;
   localparam logic [7:0] STATUS_RESET = 8'h00;

   typedef enum logic [1:0] {
      SWG_WR_NONE,
      SWG_WR_ARRAY,
      SWG_WR_STATUS
   } swg_wr_kind_e;

   typedef struct packed {
      logic sel_start;
      logic sel_end;
      logic sck_rise;
      logic sck_fall;
      logic sdi;
   } swg_link_s;
endpackage : swg_pkg

// ### hdl/swg_sync.sv
// Purpose: two-flop synchroniser with edge detect on the synced level
// Assumes: input asynchronous to clk_i
// Notes: the first stage is read only by the second stage
`timescale 1ns/1ps
module swg_sync #(
   parameter logic RESET_VAL = 1'b0
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic async_i,
   output logic level_o,
   output logic rise_o,
   output logic fall_o
);
   logic meta_q, meta_d, sync_q, sync_d, last_q, last_d;

   // next values: plain shift
   always_comb begin
      meta_d = async_i;
      sync_d = meta_q;
      last_d = sync_q;
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         meta_q <= RESET_VAL;
         sync_q <= RESET_VAL;
         last_q <= RESET_VAL;
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
         last_q <= last_d;
      end
   end

   assign level_o = sync_q;
   assign rise_o = sync_q & ~last_q;
   assign fall_o = ~sync_q & last_q;
endmodule : swg_sync

// ### hdl/swg_guard.sv
// Purpose: command acceptance and write guard of a serial eeprom
// Assumes: rst_n_i mirrors the power-on reset indication
// Notes: array storage itself lies outside; write_start_o launches it
//
// Behaviour
// - standby on reset release, reset on reassertion
// - latch cleared and standby after reset
// - no instruction before chip select seen low
// - completed write clears the write latch
// - self-timed write starts at select rise
// - array commands ignored while write runs
// - invalid opcode ignored, output stays released
// - set-latch then select high sets latch
// - clear-latch instruction clears the write latch
// - only status read served while busy
`timescale 1ns/1ps
module swg_guard
   import swg_pkg::*;
#(
   parameter int unsigned WRITE_CYCLES_P = WRITE_CYCLES
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic cs_n_i,
   input wire logic sck_i,
   input wire logic sdi_i,
   output logic sdo_o,
   output logic sdo_oe_o,
   output logic write_latch_flag_o,
   output logic busy_o,
   output logic standby_o,
   output logic write_start_o,
   output logic write_is_status_o,
   output logic [15:0] write_addr_o,
   output logic [7:0] write_data_o,
   output logic [7:0] status_wr_o
);
   // refuse a zero write time, which would never raise busy
   if (WRITE_CYCLES_P < 1) begin : g_bad_write_cycles
      $error("write time must be at least one cycle");
   end

   swg_link_s link;
   logic cs_lvl;
   logic sck_lvl;
   logic sdi_lvl;

   // all three host pins are outside the clock domain
   swg_sync #(.RESET_VAL(1'b1)) u_cs (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .async_i(cs_n_i),
      .level_o(cs_lvl), .rise_o(link.sel_end), .fall_o(link.sel_start));
   swg_sync #(.RESET_VAL(1'b0)) u_sck (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .async_i(sck_i),
      .level_o(sck_lvl), .rise_o(link.sck_rise), .fall_o(link.sck_fall));
   swg_sync #(.RESET_VAL(1'b0)) u_sdi (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .async_i(sdi_i),
      .level_o(sdi_lvl), .rise_o(), .fall_o());
   assign link.sdi = sdi_lvl;

   logic armed_q, armed_d;          // select seen low since reset
   logic active_q, active_d;        // inside an accepted selection
   logic latch_q, latch_d;
   logic [5:0] bits_q, bits_d;      // saturating bit count
   logic [7:0] op_q, op_d;
   logic [15:0] addr_q, addr_d;
   logic [7:0] data_q, data_d;
   logic [7:0] shift_q, shift_d;
   logic [2:0] sub_q, sub_d;        // bit within current data byte
   logic [7:0] out_q, out_d;
   logic oe_q, oe_d;
   logic [31:0] busy_cnt_q, busy_cnt_d;
   logic start_q, start_d;
   logic is_stat_q, is_stat_d;
   swg_wr_kind_e kind;
   logic [7:0] status_now;
   logic bad_op;

   // live status image: ready bit high while a write runs
   always_comb begin
      status_now = STATUS_RESET;
      status_now[STATUS_READY_POS] = (busy_cnt_q != 32'h0);
      status_now[STATUS_LATCH_POS] = latch_q;
   end

   // a write is kept only if the clock count ends on a whole byte
   always_comb begin
      kind = SWG_WR_NONE;
      if (op_q == OP_WRITE && bits_q >= 6'(ARRAY_WR_MIN_BITS) && sub_q == 3'h0)
         kind = SWG_WR_ARRAY;
      else if (op_q == OP_WRITE_STATUS && bits_q == 6'(STATUS_WR_BITS))
         kind = SWG_WR_STATUS;
   end

   assign bad_op = (op_q != OP_SET_LATCH) && (op_q != OP_CLEAR_LATCH) && (op_q != OP_READ_STATUS)
                   && (op_q != OP_WRITE_STATUS) && (op_q != OP_READ) && (op_q != OP_WRITE);

   // serial engine next state
   always_comb begin
      armed_d = armed_q;
      active_d = active_q;
      latch_d = latch_q;
      bits_d = bits_q;
      op_d = op_q;
      addr_d = addr_q;
      data_d = data_q;
      shift_d = shift_q;
      sub_d = sub_q;
      out_d = out_q;
      oe_d = oe_q;
      start_d = 1'b0;
      is_stat_d = is_stat_q;
      busy_cnt_d = (busy_cnt_q != 32'h0) ? busy_cnt_q - 32'h1 : 32'h0;
      if (busy_cnt_q == 32'h1) begin
         latch_d = 1'b0;
      end
      if (link.sel_start) begin
         armed_d = 1'b1;
         active_d = 1'b1;
         bits_d = 6'h0;
         sub_d = 3'h0;
         oe_d = 1'b0;
      end else if (link.sel_end && active_q) begin
         active_d = 1'b0;
         oe_d = 1'b0;
         if (busy_cnt_q == 32'h0 && bits_q == 6'(OPCODE_BITS)) begin
            if (op_q == OP_SET_LATCH) latch_d = 1'b1;
            if (op_q == OP_CLEAR_LATCH) latch_d = 1'b0;
         end
         // without the latch nothing is launched; wrong counts are dropped
         if (busy_cnt_q == 32'h0 && latch_q && kind != SWG_WR_NONE) begin
            start_d = 1'b1;
            is_stat_d = (kind == SWG_WR_STATUS);
            busy_cnt_d = 32'(WRITE_CYCLES_P);
         end
      end else if (active_q && armed_q && !cs_lvl) begin
         if (link.sck_rise) begin
            if (bits_q != 6'h3f) bits_d = bits_q + 6'h1;
            shift_d = {shift_q[6:0], link.sdi};
            if (bits_q < 6'(OPCODE_BITS)) begin
               op_d = {op_q[6:0], link.sdi};
            end else if (busy_cnt_q != 32'h0) begin
               // programming uses address and data until it ends, so a new command must not touch them
               addr_d = addr_q;
            end else if (op_q == OP_WRITE && bits_q < 6'(OPCODE_BITS + 16)) begin
               addr_d = {addr_q[14:0], link.sdi};
            end else begin
               sub_d = sub_q + 3'h1;
               if (sub_q == 3'h7) data_d = {shift_q[6:0], link.sdi};
            end
         end
         // status read answered even while busy; others silent then
         if (link.sck_fall && bits_q == 6'(OPCODE_BITS)) begin
            if (op_q == OP_READ_STATUS) begin
               out_d = status_now;
               oe_d = 1'b1;
            end else if (bad_op || busy_cnt_q != 32'h0) begin
               oe_d = 1'b0;
            end
         end else if (link.sck_fall && oe_q) begin
            out_d = {out_q[6:0], 1'b0};
         end
      end
   end

   // reset value: latch clear, idle, output released
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         armed_q <= 1'b0;
         active_q <= 1'b0;
         latch_q <= 1'b0;
         bits_q <= 6'h0;
         op_q <= 8'h00;
         addr_q <= 16'h0000;
         data_q <= 8'h00;
         shift_q <= 8'h00;
         sub_q <= 3'h0;
         out_q <= 8'h00;
         oe_q <= 1'b0;
         busy_cnt_q <= 32'h0;
         start_q <= 1'b0;
         is_stat_q <= 1'b0;
      end else begin
         armed_q <= armed_d;
         active_q <= active_d;
         latch_q <= latch_d;
         bits_q <= bits_d;
         op_q <= op_d;
         addr_q <= addr_d;
         data_q <= data_d;
         shift_q <= shift_d;
         sub_q <= sub_d;
         out_q <= out_d;
         oe_q <= oe_d;
         busy_cnt_q <= busy_cnt_d;
         start_q <= start_d;
         is_stat_q <= is_stat_d;
      end
   end

   assign sdo_o = out_q[7];
   assign sdo_oe_o = oe_q;
   assign write_latch_flag_o = latch_q;
   assign busy_o = (busy_cnt_q != 32'h0);
   assign standby_o = !active_q && (busy_cnt_q == 32'h0);
   assign write_start_o = start_q;
   assign write_is_status_o = is_stat_q;
   assign write_addr_o = addr_q;
   assign write_data_o = data_q;
   // a status write carries its byte through the data shifter, not the address
   assign status_wr_o = data_q;
endmodule : swg_guard

// ### sim/swg_host.sv
// Purpose: host spi controller model, mode 0, msb first
// Assumes: sck idles low and stands still between frames
// Notes: sdi shows the inverted last bit once a frame ends
`timescale 1ns/1ps
module swg_host (
   input wire logic clk_i,
   input wire logic sdo_i,
   input wire logic sdo_oe_i,
   output logic cs_n_o,
   output logic sck_o,
   output logic sdi_o
);
   logic [7:0] rd;
   logic oe_seen;
   // all pin changes land 1 ns after a clock edge
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask : tick
   // one frame: select low, n bits, select high after a low phase
   task automatic xfer(input logic [31:0] v, input int n);
      cs_n_o = 1'b0;
      oe_seen = 1'b0;
      for (int i = n - 1; i >= 0; i--) begin
         sdi_o = v[i];
         tick(8);
         sck_o = 1'b1;
         rd = {rd[6:0], sdo_i};
         oe_seen = oe_seen | sdo_oe_i;
         tick(8);
         sck_o = 1'b0;
      end
      tick(8);
      cs_n_o = 1'b1;
      sdi_o = ~sdi_o;
      tick(12);
   endtask : xfer
   // idle pins at time zero
   initial begin
      cs_n_o = 1'b1;
      sck_o = 1'b0;
      sdi_o = 1'b0;
   end
endmodule : swg_host

// ### sim/swg_guard_sva.sv
// Purpose: port timing checks of the write guard
// Assumes: one clock domain, async active-low reset
// Notes: busy length is counted in helper logic
`timescale 1ns/1ps
module swg_guard_sva #(
   parameter int unsigned WRITE_CYCLES_P = 20
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic cs_n_i,
   input wire logic sdo_oe_o,
   input wire logic write_latch_flag_o,
   input wire logic busy_o,
   input wire logic standby_o,
   input wire logic write_start_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   int unsigned busy_cnt_q;
   int unsigned busy_cnt_d;
   // length of the running busy stretch
   always_comb busy_cnt_d = busy_o ? busy_cnt_q + 32'h1 : 32'h0;
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) busy_cnt_q <= 32'h0;
      else busy_cnt_q <= busy_cnt_d;
   end
   sequence s_deselected; cs_n_i [*5]; endsequence
   sequence s_quiet_sel; (!cs_n_i && !busy_o) [*5]; endsequence
   a_start_then_busy: assert property (write_start_o |-> $rose(busy_o))
      else $error("busy missing after start");
   a_busy_length: assert property ($fell(busy_o) |-> busy_cnt_q == WRITE_CYCLES_P)
      else $error("busy length wrong");
   a_done_clears: assert property ($fell(busy_o) |-> ##[0:1] !write_latch_flag_o)
      else $error("latch kept after write");
   a_start_needs_latch: assert property (write_start_o |-> write_latch_flag_o)
      else $error("write without latch");
   a_busy_no_start: assert property ($past(busy_o) |-> !write_start_o)
      else $error("start while busy");
   a_busy_no_standby: assert property (busy_o |-> !standby_o)
      else $error("standby while busy");
   a_idle_released: assert property (s_deselected |-> !sdo_oe_o)
      else $error("output driven while deselected");
   a_latch_held_sel: assert property (s_quiet_sel |-> $stable(write_latch_flag_o))
      else $error("latch moved while selected");
   a_latch_on_desel: assert property ($rose(write_latch_flag_o) |-> cs_n_i)
      else $error("latch set while selected");
endmodule : swg_guard_sva
bind swg_guard swg_guard_sva #(.WRITE_CYCLES_P(WRITE_CYCLES_P)) u_swg_guard_sva (.clk_i, .rst_n_i, .cs_n_i,
   .sdo_oe_o, .write_latch_flag_o, .busy_o, .standby_o, .write_start_o);

// ### sim/swg_guard_bench.sv
// Purpose: self-checking bench of the write guard
// Assumes: the host model drives every serial pin
// Notes: a busy count of 2000 cycles, longer than the default 1250
`timescale 1ns/1ps
module swg_guard_bench;
   import swg_pkg::*;
   localparam int unsigned WC = 2000;
   logic clk_i, rst_n_i, cs_n_i, sck_i, sdi_i, sdo_o, sdo_oe_o, write_latch_flag_o, busy_o, standby_o;
   logic write_start_o, write_is_status_o;
   logic [15:0] write_addr_o;
   logic [7:0] write_data_o, status_wr_o;
   int num_errors = 0, total_checks = 0, starts = 0;
   swg_guard #(.WRITE_CYCLES_P(WC)) u_swg_guard (.clk_i, .rst_n_i, .cs_n_i, .sck_i, .sdi_i, .sdo_o, .sdo_oe_o,
      .write_latch_flag_o, .busy_o, .standby_o, .write_start_o, .write_is_status_o, .write_addr_o,
      .write_data_o, .status_wr_o);
   swg_host u_swg_host (.clk_i, .sdo_i(sdo_o), .sdo_oe_i(sdo_oe_o), .cs_n_o(cs_n_i), .sck_o(sck_i), .sdi_o(sdi_i));
   // free-running clock
   initial begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end
   // launch count; a stray pulse shows as an extra launch
   always @(posedge clk_i) if (write_start_o === 1'b1) starts++;
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %0t got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic do_reset;
      rst_n_i = 1'b0;
      u_swg_host.tick(10);
      rst_n_i = 1'b1;
      u_swg_host.tick(2);
   endtask : do_reset
   // bounded wait for the self-timed write to end
   task automatic wait_idle;
      for (int i = 0; i < WC + 100 && busy_o !== 1'b0; i++) @(posedge clk_i);
      u_swg_host.tick(4);
      chk(busy_o, 16'h0);
   endtask : wait_idle
   task automatic t_reset;
      chk(write_latch_flag_o, 16'h0);
      chk(standby_o, 16'h1);
      u_swg_host.xfer({OP_READ_STATUS, 8'h00}, 16);
      chk(u_swg_host.rd[1:0], 16'h0);
      $display("test reset done");
   endtask : t_reset
   // latch commands, unlatched and short writes
   task automatic t_guard;
      u_swg_host.xfer({OP_WRITE, 16'h0012, 8'h5a}, 32);
      chk(16'(starts), 16'h0);
      u_swg_host.xfer(OP_SET_LATCH, 8);
      chk(write_latch_flag_o, 16'h1);
      u_swg_host.xfer(OP_CLEAR_LATCH, 8);
      chk(write_latch_flag_o, 16'h0);
      u_swg_host.xfer(OP_SET_LATCH, 8);
      u_swg_host.xfer({OP_WRITE_STATUS, 4'h8}, 12);
      u_swg_host.xfer({OP_WRITE, 16'h0012, 4'h5}, 28);
      chk(16'(starts), 16'h0);
      chk(write_latch_flag_o, 16'h1);
      $display("test guard done");
   endtask : t_guard
   // array write, then commands while it runs
   task automatic t_write;
      u_swg_host.xfer({OP_WRITE, 16'h0abc, 8'hc3}, 32);
      chk(16'(starts), 16'h1);
      chk(write_addr_o, 16'h0abc);
      chk(write_data_o, 16'h00c3);
      chk(write_is_status_o, 16'h0);
      u_swg_host.xfer({OP_READ_STATUS, 8'h00}, 16);
      chk(u_swg_host.rd[1:0], 16'h3);
      u_swg_host.xfer({OP_READ, 16'h0abc, 8'h00}, 32);
      chk(u_swg_host.oe_seen, 16'h0);
      u_swg_host.xfer({OP_WRITE, 16'h0123, 8'h11}, 32);
      chk(write_addr_o, 16'h0abc);
      chk(write_data_o, 16'h00c3);
      u_swg_host.xfer(OP_SET_LATCH, 8);
      wait_idle();
      chk(write_latch_flag_o, 16'h0);
      chk(16'(starts), 16'h1);
      $display("test write done");
   endtask : t_write
   // status write, invalid opcode, reset with the latch set
   task automatic t_status;
      u_swg_host.xfer(OP_SET_LATCH, 8);
      u_swg_host.xfer({OP_WRITE_STATUS, 8'h8c}, 16);
      chk(16'(starts), 16'h2);
      chk(write_is_status_o, 16'h1);
      chk(status_wr_o, 16'h008c);
      wait_idle();
      chk(write_latch_flag_o, 16'h0);
      u_swg_host.xfer({8'hff, 8'h00}, 16);
      chk(u_swg_host.oe_seen, 16'h0);
      u_swg_host.xfer(OP_SET_LATCH, 8);
      do_reset();
      chk(write_latch_flag_o, 16'h0);
      chk(standby_o, 16'h1);
      $display("test status done");
   endtask : t_status
   task automatic end_of_test;
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : end_of_test
   // main sequence
   initial begin
      do_reset();
      t_reset();
      t_guard();
      t_write();
      t_status();
      end_of_test();
   end
   // watchdog, well beyond the expected run
   initial begin
      #150000;
      num_errors++;
      end_of_test();
   end
endmodule : swg_guard_bench
